// [short_stroke_limit_clamp.sv]
`timescale 1ns/10ps
`include "ssl_params.svh"

module short_stroke_limit_clamp
  import ssl_pkg::*;
#(
  parameter int ANGLE_W = 12,
  parameter int WORD_W = 24
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic INIT,
  input wire logic CFG_WE,
  input wire logic [11:0] CFG_ADDR,
  input wire logic [WORD_W-1:0] CFG_WDATA,
  output logic [WORD_W-1:0] INPUT_LIMIT_WORD,
  output logic [WORD_W-1:0] OUTPUT_CLAMP_WORD,
  input wire logic SHORT_STROKE_EN,
  input wire logic SEGMENTED_CORR_ON,
  input wire logic HARMONIC_CORR_ON,
  input wire logic [3:0] HARMONIC_TERM_COUNT,
  input wire logic RAW_VALID,
  input wire logic [ANGLE_W-1:0] RAW_ANGLE,
  input wire logic [ANGLE_W-1:0] ZERO_SHIFT,
  output logic SHIFTED_VALID,
  output logic [ANGLE_W-1:0] SHIFTED_ANGLE,
  input wire logic PROC_VALID,
  input wire logic [ANGLE_W-1:0] PROC_ANGLE,
  output logic OUT_VALID,
  output logic [ANGLE_W-1:0] OUT_ANGLE,
  output logic ABOVE_RANGE_FLAG,
  output logic BELOW_RANGE_FLAG,
  input wire logic FLAG_CLEAR,
  output limit_pair_t UPPER_LOWER_LIVE,
  output limit_pair_t CEIL_FLOOR_LIVE,
  output harm_load_t HARM_LOAD,
  output logic INIT_DONE
);

  initial begin
    if (ANGLE_W != 12 || WORD_W != 24) begin
      $error("short_stroke_limit_clamp supports only 12-bit angles in 24-bit words");
    end
  end

  init_state_t state;
  init_state_t next_state;
  logic load_step;
  logic next_load_step;

  logic [11:0] upper_input_limit_live;
  logic [11:0] lower_input_limit_live;
  logic [11:0] output_ceiling_live;
  logic [11:0] output_floor_live;

  wire wr_limit = CFG_WE && (CFG_ADDR == `SSL_INPUT_LIMIT_OFS);
  wire wr_clamp = CFG_WE && (CFG_ADDR == `SSL_OUTPUT_CLAMP_OFS);

  // Coefficient layout replaces the limit layout word by word
  wire coeff_mode = !SEGMENTED_CORR_ON && HARMONIC_CORR_ON;
  wire word_a_coeff = coeff_mode && (HARMONIC_TERM_COUNT > `SSL_TERMS_SLOT_A);
  wire word_b_coeff = coeff_mode && (HARMONIC_TERM_COUNT > `SSL_TERMS_SLOT_B);
  wire limits_active = SHORT_STROKE_EN && !word_a_coeff;
  wire clamps_active = SHORT_STROKE_EN && !word_b_coeff;

  wire [11:0] word_a_hi = INPUT_LIMIT_WORD[`SSL_HI_MSB:`SSL_HI_LSB];
  wire [11:0] word_a_lo = INPUT_LIMIT_WORD[`SSL_LO_MSB:`SSL_LO_LSB];
  wire [11:0] word_b_hi = OUTPUT_CLAMP_WORD[`SSL_HI_MSB:`SSL_HI_LSB];
  wire [11:0] word_b_lo = OUTPUT_CLAMP_WORD[`SSL_LO_MSB:`SSL_LO_LSB];

  harm_coeff_t coeff_a;
  harm_coeff_t coeff_b;
  assign coeff_a.phase = word_a_hi;
  assign coeff_a.step = INPUT_LIMIT_WORD[`SSL_STEP_MSB:`SSL_STEP_LSB];
  assign coeff_a.magnitude = INPUT_LIMIT_WORD[`SSL_MAG_MSB:`SSL_MAG_LSB];
  assign coeff_b.phase = word_b_hi;
  assign coeff_b.step = OUTPUT_CLAMP_WORD[`SSL_STEP_MSB:`SSL_STEP_LSB];
  assign coeff_b.magnitude = OUTPUT_CLAMP_WORD[`SSL_MAG_MSB:`SSL_MAG_LSB];

  // Zero-reference shift always applied, modulo one turn
  wire [11:0] shifted = RAW_ANGLE - ZERO_SHIFT;

  // Zero limits turn the tests off, as software is told to program them
  // The live copy decides, so a stored word written after initialisation has no effect
  wire above = limits_active && (upper_input_limit_live != 12'h000) &&
               (shifted > upper_input_limit_live);
  wire below = limits_active && (lower_input_limit_live != 12'h000) &&
               (shifted < lower_input_limit_live);
  wire [11:0] replaced = above ? output_ceiling_live :
                         below ? output_floor_live : shifted;

  // Codes are in 1/4096 turn; a ceiling of 4096 wraps to 0 in 12 bits, so the
  // ceiling test is skipped when the ceiling field is all zero
  wire ceil_hit = clamps_active && (output_ceiling_live != 12'h000) &&
                  (PROC_ANGLE > output_ceiling_live);
  wire floor_hit = clamps_active && (PROC_ANGLE < output_floor_live);
  wire [11:0] clamped = ceil_hit ? output_ceiling_live :
                        floor_hit ? output_floor_live : PROC_ANGLE;

  wire set_above = RAW_VALID && above;
  wire set_below = RAW_VALID && below;

  always_comb begin
    next_state = state;
    next_load_step = load_step;
    unique case (state)
      ST_IDLE: begin
        if (INIT) begin
          next_state = ST_LOAD;
          next_load_step = 1'b0;
        end
      end
      ST_LOAD: begin
        next_load_step = 1'b1;
        if (load_step) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (INIT) begin
          next_state = ST_LOAD;
          next_load_step = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      load_step <= 1'b0;
    end else begin
      state <= next_state;
      load_step <= next_load_step;
    end
  end

  // Stored words: writes land here, the live copies follow on initialisation
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      INPUT_LIMIT_WORD <= `SSL_INPUT_LIMIT_RST;
      OUTPUT_CLAMP_WORD <= `SSL_OUTPUT_CLAMP_RST;
    end else begin
      if (wr_limit) begin
        INPUT_LIMIT_WORD <= CFG_WDATA;
      end
      if (wr_clamp) begin
        OUTPUT_CLAMP_WORD <= CFG_WDATA;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      upper_input_limit_live <= 12'h000;
      lower_input_limit_live <= 12'h000;
      output_ceiling_live <= 12'h000;
      output_floor_live <= 12'h000;
    end else if (state == ST_LOAD && !load_step) begin
      upper_input_limit_live <= word_a_hi;
      lower_input_limit_live <= word_a_lo;
      output_ceiling_live <= word_b_hi;
      output_floor_live <= word_b_lo;
    end
  end

  // One coefficient slot per load cycle: word A first, then word B
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      HARM_LOAD <= '0;
    end else if (state == ST_LOAD) begin
      HARM_LOAD.valid <= load_step ? word_b_coeff : word_a_coeff;
      HARM_LOAD.slot <= load_step ? `SSL_HARM_SLOT_B : `SSL_HARM_SLOT_A;
      HARM_LOAD.coeff <= load_step ? coeff_b : coeff_a;
    end else begin
      HARM_LOAD.valid <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      INIT_DONE <= 1'b0;
      UPPER_LOWER_LIVE <= '0;
      CEIL_FLOOR_LIVE <= '0;
    end else begin
      INIT_DONE <= (state == ST_RUN);
      UPPER_LOWER_LIVE <= {upper_input_limit_live, lower_input_limit_live};
      CEIL_FLOOR_LIVE <= {output_ceiling_live, output_floor_live};
    end
  end

  // Flags are sticky; a new error in the clear cycle keeps the flag set
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ABOVE_RANGE_FLAG <= 1'b0;
      BELOW_RANGE_FLAG <= 1'b0;
    end else begin
      ABOVE_RANGE_FLAG <= set_above || (ABOVE_RANGE_FLAG && !FLAG_CLEAR);
      BELOW_RANGE_FLAG <= set_below || (BELOW_RANGE_FLAG && !FLAG_CLEAR);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SHIFTED_VALID <= 1'b0;
      SHIFTED_ANGLE <= 12'h000;
      OUT_VALID <= 1'b0;
      OUT_ANGLE <= 12'h000;
    end else begin
      SHIFTED_VALID <= RAW_VALID;
      SHIFTED_ANGLE <= replaced;
      OUT_VALID <= PROC_VALID;
      OUT_ANGLE <= clamped;
    end
  end

endmodule

// [ssl_params.svh]
`ifndef SSL_PARAMS_SVH
`define SSL_PARAMS_SVH
`define SSL_INPUT_LIMIT_OFS 12'h315
`define SSL_OUTPUT_CLAMP_OFS 12'h316
`define SSL_HARM_SLOT_A 8'h15
`define SSL_HARM_SLOT_B 8'h16
`define SSL_HI_MSB 23
`define SSL_HI_LSB 12
`define SSL_LO_MSB 11
`define SSL_LO_LSB 0
`define SSL_STEP_MSB 11
`define SSL_STEP_LSB 10
`define SSL_MAG_MSB 9
`define SSL_MAG_LSB 0
`define SSL_INPUT_LIMIT_RST 24'hfff000
`define SSL_OUTPUT_CLAMP_RST 24'hfff000
`define SSL_TERMS_SLOT_A 4'h9
`define SSL_TERMS_SLOT_B 4'ha
`endif

// [ssl_pkg.sv]
package ssl_pkg;
  typedef struct packed {
    logic [11:0] hi;
    logic [11:0] lo;
  } limit_pair_t;
  typedef struct packed {
    logic [11:0] phase;
    logic [1:0] step;
    logic [9:0] magnitude;
  } harm_coeff_t;
  typedef struct packed {
    logic valid;
    logic [7:0] slot;
    harm_coeff_t coeff;
  } harm_load_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } init_state_t;
endpackage

// [ssl_checker_sva.sv]
`timescale 1ns/10ps
module ssl_checker
  import ssl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CFG_WE,
  input wire logic [11:0] CFG_ADDR,
  input wire logic [23:0] CFG_WDATA,
  input wire logic [23:0] INPUT_LIMIT_WORD,
  input wire logic SHORT_STROKE_EN,
  input wire logic SEGMENTED_CORR_ON,
  input wire logic RAW_VALID,
  input wire logic [11:0] RAW_ANGLE,
  input wire logic [11:0] ZERO_SHIFT,
  input wire logic [11:0] SHIFTED_ANGLE,
  input wire logic PROC_VALID,
  input wire logic [11:0] PROC_ANGLE,
  input wire logic OUT_VALID,
  input wire logic [11:0] OUT_ANGLE,
  input wire logic ABOVE_RANGE_FLAG,
  input wire logic BELOW_RANGE_FLAG,
  input wire logic FLAG_CLEAR,
  input wire limit_pair_t UPPER_LOWER_LIVE,
  input wire limit_pair_t CEIL_FLOOR_LIVE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Shift wraps modulo a full turn, like the design
  wire logic [11:0] net_raw = RAW_ANGLE - ZERO_SHIFT;
  wire logic act = SHORT_STROKE_EN && SEGMENTED_CORR_ON;
  wire logic over = UPPER_LOWER_LIVE.hi != 12'h000 && net_raw > UPPER_LOWER_LIVE.hi;
  wire logic under = UPPER_LOWER_LIVE.lo != 12'h000 && net_raw < UPPER_LOWER_LIVE.lo;
  sequence s_write_a;
    CFG_WE && CFG_ADDR == 12'h315;
  endsequence
  sequence s_sample_on;
    RAW_VALID && act;
  endsequence
  AST_OVER: assert property (s_sample_on and over |=> ABOVE_RANGE_FLAG
    && SHIFTED_ANGLE == $past(CEIL_FLOOR_LIVE.hi)) else $error("above range missed");
  AST_UNDER: assert property (s_sample_on and !over && under |=> BELOW_RANGE_FLAG
    && SHIFTED_ANGLE == $past(CEIL_FLOOR_LIVE.lo)) else $error("below range missed");
  AST_PASS: assert property (RAW_VALID && !SHORT_STROKE_EN |=>
    SHIFTED_ANGLE == $past(net_raw)) else $error("shifted angle wrong");
  AST_CEIL: assert property (PROC_VALID && act && CEIL_FLOOR_LIVE.hi != 12'h000
    && PROC_ANGLE > CEIL_FLOOR_LIVE.hi |=> OUT_ANGLE == $past(CEIL_FLOOR_LIVE.hi))
    else $error("ceiling clamp wrong");
  AST_FLOOR: assert property (PROC_VALID && act && PROC_ANGLE < CEIL_FLOOR_LIVE.lo
    |=> OUT_ANGLE == $past(CEIL_FLOOR_LIVE.lo)) else $error("floor clamp wrong");
  AST_HOLD: assert property (ABOVE_RANGE_FLAG && !FLAG_CLEAR |=> ABOVE_RANGE_FLAG)
    else $error("above flag dropped");
  AST_WRITE: assert property (s_write_a |=> INPUT_LIMIT_WORD == $past(CFG_WDATA))
    else $error("limit word not written");
  AST_OUT_LAT: assert property (PROC_VALID |=> OUT_VALID) else $error("out valid late");
endmodule

// [tb.sv]
`timescale 1ns/10ps
module tb
  import ssl_pkg::*;
;
  logic MCLK, RST_N, INIT, CFG_WE, SHORT_STROKE_EN, SEGMENTED_CORR_ON, HARMONIC_CORR_ON;
  logic RAW_VALID, PROC_VALID, FLAG_CLEAR, OUT_VALID, SHIFTED_VALID, INIT_DONE;
  logic ABOVE_RANGE_FLAG, BELOW_RANGE_FLAG;
  logic [11:0] CFG_ADDR, RAW_ANGLE, ZERO_SHIFT, PROC_ANGLE, SHIFTED_ANGLE, OUT_ANGLE;
  logic [23:0] CFG_WDATA, INPUT_LIMIT_WORD, OUTPUT_CLAMP_WORD;
  logic [3:0] HARMONIC_TERM_COUNT;
  limit_pair_t UPPER_LOWER_LIVE, CEIL_FLOOR_LIVE;
  harm_load_t HARM_LOAD;
  harm_load_t hq[$];
  int failures = 0;
  int num_checks = 0;
  // {enable, raw, shift, expected shifted, expected out, flags}
  logic [55:0] tab [7] = '{56'h1_801_000_f00_801_2, 56'h1_800_000_800_800_0,
    56'h1_0ff_000_080_0ff_1, 56'h1_100_000_100_100_0, 56'h1_f01_400_f00_f00_2,
    56'h1_050_f50_100_080_0, 56'h0_f01_400_b01_f01_0};
  short_stroke_limit_clamp short_stroke_limit_clamp_i (.*);
  task automatic chk(string name, logic [47:0] exp, logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(logic [11:0] a, logic [23:0] d);
    @(posedge MCLK);
    CFG_WE <= 1'b1;
    CFG_ADDR <= a;
    CFG_WDATA <= d;
    @(posedge MCLK);
    CFG_WE <= 1'b0;
    #1;
  endtask
  task automatic init(logic [3:0] t);
    @(posedge MCLK);
    INIT <= 1'b1;
    HARMONIC_TERM_COUNT <= t;
    hq.delete();
    @(posedge MCLK);
    INIT <= 1'b0;
    repeat (4) @(posedge MCLK);
    #1;
  endtask
  // Flag clear is raised with the result, before the check, and acts on the next edge so each row starts clean
  task automatic sample(logic [55:0] r);
    @(posedge MCLK);
    FLAG_CLEAR <= 1'b0;
    SHORT_STROKE_EN <= r[52];
    RAW_ANGLE <= r[51:40];
    PROC_ANGLE <= r[51:40];
    ZERO_SHIFT <= r[39:28];
    RAW_VALID <= 1'b1;
    PROC_VALID <= 1'b1;
    @(posedge MCLK);
    RAW_VALID <= 1'b0;
    PROC_VALID <= 1'b0;
    FLAG_CLEAR <= 1'b1;
    #1;
  endtask
  always @(posedge MCLK) if (HARM_LOAD.valid === 1'b1) hq.push_back(HARM_LOAD);
  initial begin
    MCLK = 0;
    forever #2 MCLK = ~MCLK;
  end
  initial begin
    repeat (3000) @(posedge MCLK);
    failures++;
    stop_test();
  end
  initial begin
    {RST_N, INIT, CFG_WE, RAW_VALID, PROC_VALID, FLAG_CLEAR} = '0;
    {SHORT_STROKE_EN, SEGMENTED_CORR_ON, HARMONIC_CORR_ON} = 3'h7;
    {CFG_ADDR, CFG_WDATA, RAW_ANGLE, ZERO_SHIFT, PROC_ANGLE, HARMONIC_TERM_COUNT} = '0;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    #1;
    chk("reset words", 48'hfff000_fff000, {INPUT_LIMIT_WORD, OUTPUT_CLAMP_WORD});
    wr(12'h315, 24'h800100);
    wr(12'h316, 24'hf00080);
    wr(12'h317, 24'h123456);
    chk("words", 48'h800100_f00080, {INPUT_LIMIT_WORD, OUTPUT_CLAMP_WORD});
    init(4'hb);
    chk("live", 48'h800100_f00080, {UPPER_LOWER_LIVE, CEIL_FLOOR_LIVE});
    chk("limit layout", 2'b10, {INIT_DONE, hq.size() != 0});
    for (int i = 0; i < 7; i++) begin
      sample(tab[i]);
      chk("valids", 2'b11, {SHIFTED_VALID, OUT_VALID});
      chk("shifted", tab[i][27:16], SHIFTED_ANGLE);
      chk("out", tab[i][15:4], OUT_ANGLE);
      chk("flags", tab[i][1:0], {ABOVE_RANGE_FLAG, BELOW_RANGE_FLAG});
    end
    SEGMENTED_CORR_ON <= 1'b0;
    wr(12'h315, 24'habc955);
    wr(12'h316, 24'h1236aa);
    for (int t = 9; t < 12; t++) begin
      init(4'(t));
      chk("load count", 33'(t - 9), 33'(hq.size()));
    end
    chk("slot a", 33'h1_15abc955, hq[0]);
    chk("slot b", 33'h1_161236aa, hq[1]);
    SEGMENTED_CORR_ON <= 1'b1;
    wr(12'h315, 24'h000000);
    wr(12'h316, 24'h000000);
    init(4'hb);
    sample(56'h1_fff_000_fff_fff_0);
    chk("open shifted", 12'hfff, SHIFTED_ANGLE);
    chk("open out", 12'hfff, OUT_ANGLE);
    chk("open flags", 2'b00, {ABOVE_RANGE_FLAG, BELOW_RANGE_FLAG});
    stop_test();
  end
endmodule
bind short_stroke_limit_clamp ssl_checker chk_i (.*);
